// file: inc/ogen_consts.svh
// constants of the oscillator and pll clock generator: offsets, fields, resets, counts
// assumes it is included by bare name from design files
// Operation
// - oscillator off, slow clock selected after reset
// - clearing enable clears the stable flag
// - enabling write clears stable, loads, counts per 8
// - startup count field is eight bits
// - counter at zero sets stable flag, interrupt
// - tally starts after next slow rising edge
// - sixteenth slow falling edge stops tally, ready
// - input divider takes values 1 to 255
// - zero divider holds output low, resets zero
// - output ratio is (multiplier+1)/divider
// - zero multiplier or zero divider disables pll, else enables
// - re-enable or change clears lock, loads count
// - settle counter runs on slow clock, sets lock
// - slow clock always runs, drives counters
`ifndef OGEN_CONSTS_SVH
`define OGEN_CONSTS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OGEN_OSC_CTRL_OFS   8'h00
`define OGEN_FREQ_OFS       8'h04
`define OGEN_PLL_A_OFS      8'h08
`define OGEN_PLL_B_OFS      8'h0c
`define OGEN_STATUS_OFS     8'h10
`define OGEN_MASK_OFS       8'h14
`define OGEN_PUMP_OFS       8'h18
// ****************************************
// field positions
// ****************************************
`define OGEN_OSC_EN_BIT     0
`define OGEN_OSC_BYP_BIT    1
`define OGEN_OSC_SEL_BIT    2
`define OGEN_OSC_CNT_LSB    8
`define OGEN_FREQ_RDY_BIT   16
`define OGEN_PLL_DIV_LSB    0
`define OGEN_PLL_CNT_LSB    8
`define OGEN_PLL_MUL_LSB    16
`define OGEN_PLL_B29_BIT    29
`define OGEN_ST_STABLE_BIT  0
`define OGEN_ST_FIRST_PLL_SETTLED_FLAG_BIT   1
`define OGEN_ST_SECOND_PLL_SETTLED_FLAG_BIT   2
`define OGEN_ST_FRDY_BIT    3
// ****************************************
// reset values and timing
// ****************************************
`define OGEN_OSC_CTRL_RST   32'h0000_0000
`define OGEN_PLL_RST        32'h0000_0000
`define OGEN_ACLK_HZ        40000000
`define OGEN_SLOW_HZ        32768
`define OGEN_SLOW_HALF      (`OGEN_ACLK_HZ / (2 * `OGEN_SLOW_HZ))
`define OGEN_OSC_PRESCALE   8
`define OGEN_MEAS_PERIODS   16
`define OGEN_RESP_OKAY      2'b00
`define OGEN_RESP_SLVERR    2'b10
`endif

// file: inc/ogen_pkg.sv
// types of the oscillator and pll clock generator
// assumes the constants header is compiled alongside
package ogen_pkg;
  typedef struct packed {
    logic [10:0] feedback_scale_factor;
    logic [5:0]  pll_settle_count;
    logic [7:0]  div;
  } ogen_pll_cfg_s;

  typedef enum logic [3:0] {
    OGEN_MEAS_IDLE  = 4'b0001,
    OGEN_MEAS_ARM   = 4'b0010,
    OGEN_MEAS_COUNT = 4'b0100,
    OGEN_MEAS_DONE  = 4'b1000
  } ogen_meas_e;
endpackage

// file: rtl/ogen_pll_ctl.sv
// one divider and pll control channel: input divider, enable, settle counter
// assumes ref_edge and slow_tick are one-cycle pulses on aclk
`timescale 1ns/1ps
`default_nettype none
`include "ogen_consts.svh"
module ogen_pll_ctl (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // timing pulses
  input  wire logic                   slow_tick,
  input  wire logic                   ref_edge,
  // configuration write
  input  wire logic                   cfg_we,
  input  wire ogen_pkg::ogen_pll_cfg_s cfg_wdata,
  // state
  output ogen_pkg::ogen_pll_cfg_s     cfg_r,
  output logic                        settled_r,
  output logic                        ref_pulse_r,
  output logic                        pll_run,
  output logic [11:0]                 mul_plus_one
);
  logic [7:0] div_cnt_r;
  logic [5:0] settle_cnt_r;
  logic       settling_r;
  logic       changed;

  // any differing write counts as a change, re-enable included
  assign changed      = cfg_we && (cfg_wdata != cfg_r);
  assign pll_run      = (cfg_r.div != 8'h00) && (cfg_r.feedback_scale_factor != 11'h000);
  assign mul_plus_one = {1'b0, cfg_r.feedback_scale_factor} + 12'h001;

  // ****************************************
  // configuration
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= ogen_pkg::ogen_pll_cfg_s'(25'(`OGEN_PLL_RST));
    end else if (cfg_we) begin
      cfg_r <= cfg_wdata;
    end
  end

  // ****************************************
  // input divider, 1 to 255, silent at 0
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r   <= 8'h00;
      ref_pulse_r <= 1'b0;
    end else if (cfg_r.div == 8'h00 || changed) begin
      div_cnt_r   <= 8'h00;
      ref_pulse_r <= 1'b0;
    end else if (ref_edge) begin
      if (div_cnt_r >= cfg_r.div - 8'h01) begin
        div_cnt_r   <= 8'h00;
        ref_pulse_r <= 1'b1;
      end else begin
        div_cnt_r   <= div_cnt_r + 8'h01;
        ref_pulse_r <= 1'b0;
      end
    end else begin
      ref_pulse_r <= 1'b0;
    end
  end

  // ****************************************
  // settle counter and lock flag
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_r <= 6'h00;
      settling_r   <= 1'b0;
      settled_r    <= 1'b0;
    end else if (changed) begin
      settled_r    <= 1'b0;
      settle_cnt_r <= cfg_wdata.pll_settle_count;
      settling_r   <= (cfg_wdata.feedback_scale_factor != 11'h000);
    end else if (settling_r && slow_tick) begin
      if (settle_cnt_r <= 6'h01) begin
        settle_cnt_r <= 6'h00;
        settling_r   <= 1'b0;
        settled_r    <= 1'b1;
      end else begin
        settle_cnt_r <= settle_cnt_r - 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/ogen_top.sv
// oscillator and pll clock generator with an axi4-lite register slave
// assumes crystal_input_pin is synchronous to aclk and slower than half its rate
`timescale 1ns/1ps
`default_nettype none
`include "ogen_consts.svh"
module ogen_top #(
  parameter int SLOW_HALF = `OGEN_SLOW_HALF
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // crystal side
  input  wire logic        crystal_input_pin,
  output logic             crystal_osc_enable,
  output logic             external_clock_bypass,
  output logic             main_clock_select,
  // pll side
  output logic             first_pll_run,
  output logic             first_pll_ref,
  output logic [11:0]      first_pll_mul_plus_one,
  output logic [7:0]       first_pll_div,
  output logic             second_pll_run,
  output logic             second_pll_ref,
  output logic [11:0]      second_pll_mul_plus_one,
  output logic [7:0]       second_pll_div,
  output logic             first_pll_charge_pump_bit,
  // slow clock and interrupt
  output logic             low_rate_clock,
  output logic             clock_irq
);
  // ****************************************
  // declarations
  // ****************************************
  logic [$clog2(SLOW_HALF+1)-1:0] half_cnt_r;
  logic                    slow_rise;
  logic                    slow_fall;
  logic                    xtal_d_r;
  logic                    xtal_edge;
  logic [31:0]             osc_ctrl_r;
  logic [7:0]              startup_cnt_r;
  logic [2:0]              prescale_r;
  logic                    starting_r;
  logic                    crystal_osc_stable_flag;
  ogen_pkg::ogen_meas_e    meas_r;
  logic [4:0]              fall_cnt_r;
  logic [15:0]             crystal_cycle_tally;
  logic                    freq_measure_ready_flag;
  logic [3:0]              irq_mask_r;
  logic [3:0]              status;
  logic                    aw_held_r;
  logic                    w_held_r;
  logic [7:0]              waddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic                    wr_fire;
  logic                    osc_we;
  logic                    pll_a_we;
  logic                    pll_b_we;
  logic [31:0]             wmerged;
  ogen_pkg::ogen_pll_cfg_s pll_a_cfg;
  ogen_pkg::ogen_pll_cfg_s pll_b_cfg;
  logic                    first_pll_settled_flag;
  logic                    second_pll_settled_flag;
  logic                    pump_r;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == `OGEN_OSC_CTRL_OFS) || (a == `OGEN_FREQ_OFS) || (a == `OGEN_PLL_A_OFS) ||
           (a == `OGEN_PLL_B_OFS) || (a == `OGEN_STATUS_OFS) || (a == `OGEN_MASK_OFS) ||
           (a == `OGEN_PUMP_OFS);
  endfunction

  // ****************************************
  // slow clock divider, free running
  // ****************************************
  // never gated by any register: the counters below depend on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt_r     <= '0;
      low_rate_clock <= 1'b0;
    end else if (half_cnt_r >= ($bits(half_cnt_r))'(SLOW_HALF - 1)) begin
      half_cnt_r     <= '0;
      low_rate_clock <= ~low_rate_clock;
    end else begin
      half_cnt_r     <= half_cnt_r + 1'b1;
    end
  end

  assign slow_rise = (half_cnt_r >= ($bits(half_cnt_r))'(SLOW_HALF - 1)) && !low_rate_clock;
  assign slow_fall = (half_cnt_r >= ($bits(half_cnt_r))'(SLOW_HALF - 1)) && low_rate_clock;

  // crystal clock rising edges, pin taken as synchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_d_r <= 1'b0;
    end else begin
      xtal_d_r <= crystal_input_pin;
    end
  end

  assign xtal_edge = crystal_input_pin && !xtal_d_r;

  // ****************************************
  // axi4-lite write path
  // ****************************************
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wmerged       = merge(osc_ctrl_r, wdata_r, wstrb_r);
  assign osc_we        = wr_fire && (waddr_r == `OGEN_OSC_CTRL_OFS);
  assign pll_a_we      = wr_fire && (waddr_r == `OGEN_PLL_A_OFS);
  assign pll_b_we      = wr_fire && (waddr_r == `OGEN_PLL_B_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      waddr_r   <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      waddr_r   <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OGEN_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(waddr_r) ? `OGEN_RESP_OKAY : `OGEN_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // software written registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ctrl_r <= `OGEN_OSC_CTRL_RST;
    end else if (osc_we) begin
      osc_ctrl_r <= wmerged & 32'h0000_ff07;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= 4'h0;
      pump_r     <= 1'b0;
    end else if (wr_fire && waddr_r == `OGEN_MASK_OFS && wstrb_r[0]) begin
      irq_mask_r <= wdata_r[3:0];
    end else if (wr_fire && waddr_r == `OGEN_PUMP_OFS && wstrb_r[0]) begin
      pump_r     <= wdata_r[0];
    end
  end

  assign crystal_osc_enable        = osc_ctrl_r[`OGEN_OSC_EN_BIT];
  // bypass is only honoured by the pad when enable is low, software's duty
  assign external_clock_bypass     = osc_ctrl_r[`OGEN_OSC_BYP_BIT];
  assign main_clock_select         = osc_ctrl_r[`OGEN_OSC_SEL_BIT] && crystal_osc_stable_flag;
  assign first_pll_charge_pump_bit = pump_r;

  // ****************************************
  // oscillator startup counter
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_cnt_r           <= 8'h00;
      prescale_r              <= 3'h0;
      starting_r              <= 1'b0;
      crystal_osc_stable_flag <= 1'b0;
    end else if (osc_we && !wmerged[`OGEN_OSC_EN_BIT]) begin
      starting_r              <= 1'b0;
      crystal_osc_stable_flag <= 1'b0;
    end else if (osc_we && !osc_ctrl_r[`OGEN_OSC_EN_BIT]) begin
      startup_cnt_r           <= wmerged[`OGEN_OSC_CNT_LSB +: 8];
      prescale_r              <= 3'h0;
      starting_r              <= 1'b1;
      crystal_osc_stable_flag <= 1'b0;
    end else if (starting_r && slow_rise) begin
      if (prescale_r == 3'(`OGEN_OSC_PRESCALE - 1)) begin
        prescale_r <= 3'h0;
        if (startup_cnt_r <= 8'h01) begin
          startup_cnt_r           <= 8'h00;
          starting_r              <= 1'b0;
          crystal_osc_stable_flag <= 1'b1;
        end else begin
          startup_cnt_r <= startup_cnt_r - 8'h01;
        end
      end else begin
        prescale_r <= prescale_r + 3'h1;
      end
    end
  end

  // ****************************************
  // crystal frequency measurement
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_r <= ogen_pkg::OGEN_MEAS_IDLE;
    end else if (!crystal_osc_stable_flag) begin
      meas_r <= ogen_pkg::OGEN_MEAS_IDLE;
    end else begin
      case (meas_r)
        ogen_pkg::OGEN_MEAS_IDLE: begin
          meas_r <= ogen_pkg::OGEN_MEAS_ARM;
        end
        ogen_pkg::OGEN_MEAS_ARM: begin
          if (slow_rise) begin
            meas_r <= ogen_pkg::OGEN_MEAS_COUNT;
          end
        end
        ogen_pkg::OGEN_MEAS_COUNT: begin
          if (slow_fall && fall_cnt_r == 5'(`OGEN_MEAS_PERIODS - 1)) begin
            meas_r <= ogen_pkg::OGEN_MEAS_DONE;
          end
        end
        ogen_pkg::OGEN_MEAS_DONE: begin
          meas_r <= ogen_pkg::OGEN_MEAS_DONE;
        end
        default: begin
          meas_r <= ogen_pkg::OGEN_MEAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall_cnt_r          <= 5'h00;
      crystal_cycle_tally <= 16'h0000;
    end else if (meas_r == ogen_pkg::OGEN_MEAS_ARM) begin
      fall_cnt_r          <= 5'h00;
      crystal_cycle_tally <= 16'h0000;
    end else if (meas_r == ogen_pkg::OGEN_MEAS_COUNT) begin
      if (slow_fall) begin
        fall_cnt_r <= fall_cnt_r + 5'h01;
      end
      if (xtal_edge) begin
        crystal_cycle_tally <= crystal_cycle_tally + 16'h0001;
      end
    end
  end

  assign freq_measure_ready_flag = (meas_r == ogen_pkg::OGEN_MEAS_DONE);

  // ****************************************
  // two pll channels
  // ****************************************
  // bit 29 of the first pll word is write-only and not stored
  ogen_pll_ctl u_pll_a (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .slow_tick    (slow_rise),
    .ref_edge     (xtal_edge),
    .cfg_we       (pll_a_we),
    .cfg_wdata    (ogen_pkg::ogen_pll_cfg_s'({wdata_r[26:16], wdata_r[13:8], wdata_r[7:0]})),
    .cfg_r        (pll_a_cfg),
    .settled_r    (first_pll_settled_flag),
    .ref_pulse_r  (first_pll_ref),
    .pll_run      (first_pll_run),
    .mul_plus_one (first_pll_mul_plus_one)
  );

  ogen_pll_ctl u_pll_b (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .slow_tick    (slow_rise),
    .ref_edge     (xtal_edge),
    .cfg_we       (pll_b_we),
    .cfg_wdata    (ogen_pkg::ogen_pll_cfg_s'({wdata_r[26:16], wdata_r[13:8], wdata_r[7:0]})),
    .cfg_r        (pll_b_cfg),
    .settled_r    (second_pll_settled_flag),
    .ref_pulse_r  (second_pll_ref),
    .pll_run      (second_pll_run),
    .mul_plus_one (second_pll_mul_plus_one)
  );

  assign first_pll_div  = pll_a_cfg.div;
  assign second_pll_div = pll_b_cfg.div;

  // ****************************************
  // status and interrupt
  // ****************************************
  assign status    = {freq_measure_ready_flag, second_pll_settled_flag,
                      first_pll_settled_flag, crystal_osc_stable_flag};
  assign clock_irq = |(status & irq_mask_r);

  // ****************************************
  // axi4-lite read path
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OGEN_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ? `OGEN_RESP_OKAY : `OGEN_RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        `OGEN_OSC_CTRL_OFS: s_axi_rdata <= osc_ctrl_r;
        `OGEN_FREQ_OFS:     s_axi_rdata <= {15'h0000, freq_measure_ready_flag, crystal_cycle_tally};
        `OGEN_PLL_A_OFS:    s_axi_rdata <= {5'h00, pll_a_cfg.feedback_scale_factor, 2'b00,
                                            pll_a_cfg.pll_settle_count, pll_a_cfg.div};
        `OGEN_PLL_B_OFS:    s_axi_rdata <= {5'h00, pll_b_cfg.feedback_scale_factor, 2'b00,
                                            pll_b_cfg.pll_settle_count, pll_b_cfg.div};
        `OGEN_STATUS_OFS:   s_axi_rdata <= {28'h000_0000, status};
        `OGEN_MASK_OFS:     s_axi_rdata <= {28'h000_0000, irq_mask_r};
        `OGEN_PUMP_OFS:     s_axi_rdata <= {31'h0000_0000, pump_r};
        default:            s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/ogen_props.sv
// checker of the clock generator top: pin-level timing relations
// assumes it is bound into every generator top instance
`timescale 1ns/1ps
`default_nettype none
module ogen_props #(
  parameter int SLOW_HALF = 4
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // observed outputs
  input wire logic        crystal_osc_enable,
  input wire logic        main_clock_select,
  input wire logic        first_pll_run,
  input wire logic        first_pll_ref,
  input wire logic [11:0] first_pll_mul_plus_one,
  input wire logic [7:0]  first_pll_div,
  input wire logic        second_pll_run,
  input wire logic        second_pll_ref,
  input wire logic [7:0]  second_pll_div,
  input wire logic        low_rate_clock,
  input wire logic        clock_irq
);
  // ****************************************
  // properties
  // ****************************************
  localparam int HALF_M1 = SLOW_HALF - 1;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ref is registered, so it may still show one stale pulse as div drops to zero
  sequence s_a_quiet;
    !first_pll_run ##1 !first_pll_ref;
  endsequence
  sequence s_b_quiet;
    !second_pll_run ##1 !second_pll_ref;
  endsequence
  sequence s_high_half;
    (low_rate_clock throughout ##HALF_M1 1'h1) ##1 !low_rate_clock;
  endsequence
  a_reset_osc_off: assert property ($rose(aresetn) |-> !crystal_osc_enable && !main_clock_select)
    else $error("oscillator or clock select on after reset");
  a_reset_quiet: assert property ($rose(aresetn) |-> !clock_irq && !first_pll_run && !second_pll_run)
    else $error("irq or pll active after reset");
  a_sel_needs_en: assert property (main_clock_select |-> crystal_osc_enable)
    else $error("main clock selected with oscillator off");
  a_div_zero_a: assert property (first_pll_div == 8'h00 |-> s_a_quiet)
    else $error("first pll active with zero divider");
  a_div_zero_b: assert property (second_pll_div == 8'h00 |-> s_b_quiet)
    else $error("second pll active with zero divider");
  a_mul_zero_off: assert property (first_pll_mul_plus_one == 12'h001 |-> !first_pll_run)
    else $error("first pll runs with zero multiplier");
  a_ref_single: assert property (first_pll_ref |=> !first_pll_ref)
    else $error("reference pulse longer than one cycle");
  a_slow_half: assert property ($rose(low_rate_clock) |-> s_high_half)
    else $error("slow clock half period wrong");
endmodule
bind ogen_top ogen_props #(.SLOW_HALF(SLOW_HALF)) u_props (
  .aclk(aclk), .aresetn(aresetn), .crystal_osc_enable(crystal_osc_enable),
  .main_clock_select(main_clock_select), .first_pll_run(first_pll_run),
  .first_pll_ref(first_pll_ref), .first_pll_mul_plus_one(first_pll_mul_plus_one),
  .first_pll_div(first_pll_div), .second_pll_run(second_pll_run),
  .second_pll_ref(second_pll_ref), .second_pll_div(second_pll_div),
  .low_rate_clock(low_rate_clock), .clock_irq(clock_irq)
);
`default_nettype wire

// file: tb/testbench.sv
// directed testbench of the clock generator over axi4-lite
// assumes a shortened slow clock and a crystal at a quarter of aclk
`timescale 1ns/1ps
`default_nettype none
`include "ogen_consts.svh"
module testbench;
  // ****************************************
  // signals, tasks and tests
  // ****************************************
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, a_div, b_div;
  logic [31:0] wdata = 32'h0, rd = 32'h0, rdata;
  logic [1:0]  xtal = 2'h0, resp, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, osc_en, byp, sel, pump, slow, irq;
  logic        a_run, a_ref, b_run, b_ref;
  logic [11:0] a_mul, b_mul;
  int          errors = 0;
  int          samples_checked = 0;
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) xtal <= xtal + 2'h1;
  ogen_top #(.SLOW_HALF(4)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .crystal_input_pin(xtal[1]),
    .crystal_osc_enable(osc_en), .external_clock_bypass(byp), .main_clock_select(sel),
    .first_pll_run(a_run), .first_pll_ref(a_ref), .first_pll_mul_plus_one(a_mul),
    .first_pll_div(a_div), .second_pll_run(b_run), .second_pll_ref(b_ref),
    .second_pll_mul_plus_one(b_mul), .second_pll_div(b_div),
    .first_pll_charge_pump_bit(pump), .low_rate_clock(slow), .clock_irq(irq)
  );
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang;
    errors++;
    print_verdict;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // handshakes are judged at the negedge so the rising edge never races the comb readies
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ag, wg, bg;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (int n = 0; n <= 50; n++) begin
      if (n == 50) hang;
      @(negedge aclk);
      ag   = awvalid && awready;
      wg   = wvalid && wready;
      bg   = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ag) awvalid <= 1'h0;
      if (wg) wvalid <= 1'h0;
      if (bg) break;
    end
    bready <= 1'h0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    logic ag, rg;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (int n = 0; n <= 50; n++) begin
      if (n == 50) hang;
      @(negedge aclk);
      ag   = arvalid && arready;
      rg   = rvalid;
      rd   = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ag) arvalid <= 1'h0;
      if (rg) break;
    end
    rready <= 1'h0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rdreg(a);
    chk(nm, e, rd);
  endtask
  task automatic wait_irq(output int t, input int lim);
    t = 0;
    while (irq !== 1'h1) begin
      @(negedge aclk);
      t++;
      if (t > lim) hang;
    end
  endtask
  task automatic count_ref(output int k);
    k = 0;
    repeat (120) begin
      @(negedge aclk);
      if (a_ref === 1'h1) k++;
    end
  endtask
  initial begin
    int t;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    chk("osc enable", 32'h0, 32'(osc_en));
    chk("clock select", 32'h0, 32'(sel));
    chk("pll a div", 32'h0, 32'(a_div));
    rchk("osc ctrl", `OGEN_OSC_CTRL_OFS, `OGEN_OSC_CTRL_RST);
    rchk("pll a cfg", `OGEN_PLL_A_OFS, `OGEN_PLL_RST);
    rchk("unmapped", 8'h1c, 32'h0);
    chk("unmapped resp", 32'(`OGEN_RESP_SLVERR), 32'(resp));
    wr(8'h1c, 32'h1);
    chk("unmapped wresp", 32'(`OGEN_RESP_SLVERR), 32'(resp));
    $display("test reset done");
    wr(`OGEN_MASK_OFS, 32'h1);
    chk("mask wresp", 32'(`OGEN_RESP_OKAY), 32'(resp));
    wr(`OGEN_OSC_CTRL_OFS, 32'h0000_ff05);
    rchk("stable cleared", `OGEN_STATUS_OFS, 32'h0);
    wait_irq(t, 17000);
    // full eight bit count: 255 steps of eight slow periods of eight aclk
    chk("startup wait", 32'h1, 32'(t >= 16300 && t <= 16330));
    chk("clock select", 32'h1, 32'(sel));
    for (t = 0; t < 60 && rd[16] !== 1'h1; t++) rdreg(`OGEN_FREQ_OFS);
    chk("freq ready", 32'h1, 32'(rd[16]));
    chk("tally", 32'h1, 32'(rd[15:0] >= 16'h1f && rd[15:0] <= 16'h20));
    wr(`OGEN_MASK_OFS, 32'h0);
    chk("irq masked", 32'h0, 32'(irq));
    wr(`OGEN_OSC_CTRL_OFS, 32'h0000_0002);
    chk("bypass", 32'h1, 32'(byp));
    rchk("stable dropped", `OGEN_STATUS_OFS, 32'h0);
    chk("clock select", 32'h0, 32'(sel));
    $display("test oscillator done");
    wr(`OGEN_PUMP_OFS, 32'h1);
    chk("pump bit", 32'h1, 32'(pump));
    wr(`OGEN_MASK_OFS, 32'h2);
    wr(`OGEN_PLL_A_OFS, 32'h2004_0503);
    chk("pll a mul", 32'h5, 32'(a_mul));
    chk("pll a run", 32'h1, 32'(a_run));
    rchk("lock cleared", `OGEN_STATUS_OFS, 32'h0);
    wait_irq(t, 100);
    chk("settle wait", 32'h1, 32'(t >= 25 && t <= 45));
    count_ref(t);
    chk("ref pulses", 32'h1, 32'(t >= 9 && t <= 11));
    rchk("pll a readback", `OGEN_PLL_A_OFS, 32'h0004_0503);
    wr(`OGEN_PLL_A_OFS, 32'h2000_0503);
    chk("pll a run", 32'h0, 32'(a_run));
    rchk("lock dropped", `OGEN_STATUS_OFS, 32'h0);
    wr(`OGEN_PLL_A_OFS, 32'h2004_0500);
    count_ref(t);
    chk("ref div zero", 32'h0, 32'(t));
    chk("pll a run", 32'h0, 32'(a_run));
    wr(`OGEN_PLL_B_OFS, 32'h000a_02ff);
    chk("pll b div", 32'hff, 32'(b_div));
    chk("pll b run", 32'h1, 32'(b_run));
    chk("pll b mul", 32'hb, 32'(b_mul));
    $display("test pll done");
    print_verdict;
  end
endmodule
`default_nettype wire
